// ---- design/fsp_regs.vh ----
`ifndef FSP_REGS_VH
`define FSP_REGS_VH

// Status register bit positions
`define FSP_SR_LOCK_BIT      7
`define FSP_SR_EXT3_BIT      6
`define FSP_SR_ANCHOR_BIT    5
`define FSP_SR_EXT_LO_MSB    4
`define FSP_SR_EXT_LO_LSB    2
`define FSP_SR_WEL_BIT       1
`define FSP_SR_BUSY_BIT      0

// Reset values
`define FSP_NV_RESET         6'h00
`define FSP_SR_RESET         8'h00

// Decoded command codes
`define FSP_OP_NOP           4'h0
`define FSP_OP_RD_SR         4'h1
`define FSP_OP_WR_SR         4'h2
`define FSP_OP_WREN          4'h3
`define FSP_OP_PROG          4'h4
`define FSP_OP_ERASE         4'h5
`define FSP_OP_CHIP_ERASE    4'h6
`define FSP_OP_WR_NVCR       4'h7
`define FSP_OP_RD_PARAM      4'h8

// Busy durations in clock cycles
`define FSP_SR_WR_CYCLES     16'h0008
`define FSP_NVCR_WR_CYCLES   16'h0008
`define FSP_PROG_CYCLES      16'h0010
`define FSP_ERASE_CYCLES     16'h0040
`define FSP_CHIP_CYCLES      16'h0100

// Address map
`define FSP_BLOCK_SHIFT      17
`define FSP_PARAM_ID_LSB     8'h00
`define FSP_PARAM_ID_MSB     8'hff
`define FSP_PARAM_TBL_PTR    8'h30

`endif

// ---- design/fsp_map.v ----
`timescale 1ns/10ps
`default_nettype none
`include "fsp_regs.vh"

module fsp_map #(
    parameter ADDR_W = 25
) (
    input  wire [24:0] addr,
    input  wire        sector_64k,
    input  wire [3:0]  extent,
    input  wire        from_bottom,
    output wire [1:0]  bank,
    output wire [8:0]  sector,
    output wire [9:0]  sub32,
    output wire [12:0] sub4,
    output wire        protected_hit
);
    localparam [8:0] NBLK = 9'h001 << (ADDR_W - `FSP_BLOCK_SHIFT);
    localparam [24:0] AMASK = (25'h0000001 << ADDR_W) - 25'h0000001;

    wire [24:0] am;
    wire [8:0]  blk;
    reg  [8:0]  cnt;
    reg         whole;
    reg         hit;

    assign am = addr & AMASK;
    assign blk = {1'b0, am[24:17]};
    // Both layouts number sectors upward from zero; bank is top quarter
    assign sector = sector_64k ? am[24:16] : {1'b0, am[24:17]}; // [R12]
    assign bank = am[ADDR_W-1 -: 2]; // [R10] [R11]
    assign sub32 = am[24:15]; // [R12]
    assign sub4 = am[24:12]; // [R12]

    always @*
    begin
        cnt = 9'h000;
        whole = 1'b0;
        if (extent >= 4'h9)
        begin
            whole = 1'b1;
        end
        else if (extent != 4'h0)
        begin
            cnt = 9'h001 << (extent - 4'h1); // [R14]
            whole = (cnt >= NBLK); // [R14]
        end
        if (extent == 4'h0)
        begin
            hit = 1'b0;
        end
        else if (whole)
        begin
            hit = 1'b1;
        end
        else if (from_bottom)
        begin
            hit = (blk < cnt); // [R05]
        end
        else
        begin
            hit = (blk >= NBLK - cnt); // [R05]
        end
    end

    assign protected_hit = hit; // [R06]
endmodule // fsp_map
`default_nettype wire

// ---- design/fsp_top.v ----
`timescale 1ns/10ps
`default_nettype none
`include "fsp_regs.vh"

// Function
// [R01] Status read returns the register; status write updates it.
// [R02] Lock bit 7 set with protect pin low makes status writes ignored.
// [R03] Hardware protection ends only when the protect pin goes high.
// [R04] Lock bit is nonvolatile; 0 permits status writes, default 0. Here reset reloads it to 0 like the volatile bits.
// [R05] Bit 5 anchors protected region: 0 top, 1 bottom.
// [R06] Extent bits 6 and 4:2 nonzero reject program/erase to protected area.
// [R07] Write permit latch bit 1 is volatile, cleared at power-up.
// [R08] Write-enable command sets the write permit latch.
// [R09] Busy bit 0 is high during status, config, program or erase.
// [R10] 128KB sectors: four banks of consecutive equal sector groups.
// [R11] 64KB sectors: four banks of consecutive equal sector groups.
// [R12] 64KB layout: 4KB and 32KB subsectors, sectors numbered upward.
// [R13] Parameter table holds mandatory header FF00h pointing to basic table.
// [R14] Extent n protects 2^(n-1) 128KB blocks; large values protect all.
// [R15] Chip erase runs only when every extent bit is zero.
// [R16] Busy bit always equals inverse of flag status ready bit.
// [R17] Write permit latch clears when status write, program or erase ends.
// [R18] Writes, programs, erases ignored while latch clear or device busy.
module fsp_top #(
    parameter ADDR_W = 25
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        write_protect_n,
    input  wire        sector_64k,
    input  wire        cmd_valid,
    input  wire [3:0]  cmd_op,
    input  wire [24:0] cmd_addr,
    input  wire [7:0]  cmd_wdata,
    output reg  [7:0]  flash_status_q,
    output reg         flag_ready_q,
    output reg  [7:0]  rdata_q,
    output reg         rdata_valid_q,
    output reg         cmd_reject_q,
    output reg         array_start_q,
    output reg  [1:0]  bank_q,
    output reg  [8:0]  sector_q,
    output reg  [9:0]  sub32_q,
    output reg  [12:0] sub4_q
);
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_BUSY = 2'b10;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [15:0] cnt_q;
    reg  [15:0] cnt_d;
    reg         lock_q;
    reg         anchor_q;
    reg  [3:0]  extent_q;
    reg         wel_q;
    reg         lock_d;
    reg         anchor_d;
    reg  [3:0]  extent_d;
    reg         wel_d;
    reg         reject_d;
    reg         start_d;
    reg  [7:0]  rdata_d;
    reg         rvalid_d;
    reg  [7:0]  param_byte;
    reg         is_write;

    wire        busy;
    wire        hw_locked;
    wire        prot_hit;
    wire [1:0]  bank_w;
    wire [8:0]  sector_w;
    wire [9:0]  sub32_w;
    wire [12:0] sub4_w;
    wire [7:0]  status_now;

    fsp_map #(
        .ADDR_W        (ADDR_W)
    ) u_map (
        .addr          (cmd_addr),
        .sector_64k    (sector_64k),
        .extent        (extent_q),
        .from_bottom   (anchor_q),
        .bank          (bank_w),
        .sector        (sector_w),
        .sub32         (sub32_w),
        .sub4          (sub4_w),
        .protected_hit (prot_hit)
    );

    assign busy = (state_q == ST_BUSY);
    // Pin high releases the lock at once, no command needed
    assign hw_locked = lock_q & ~write_protect_n; // [R02] [R03]
    assign status_now = {lock_q, extent_q[3], anchor_q, extent_q[2:0], wel_q, busy};

    // Small discoverable table decoded from cmd_addr[4:0], so it repeats every 32 bytes; unlisted offsets read as erased
    always @*
    begin
        case (cmd_addr[4:0])
            5'h00: param_byte = 8'h53;
            5'h01: param_byte = 8'h46;
            5'h02: param_byte = 8'h44;
            5'h03: param_byte = 8'h50;
            5'h04: param_byte = 8'h06;
            5'h05: param_byte = 8'h01;
            5'h06: param_byte = 8'h00;
            5'h07: param_byte = 8'hff;
            5'h08: param_byte = `FSP_PARAM_ID_LSB; // [R13]
            5'h09: param_byte = 8'h06;
            5'h0a: param_byte = 8'h01;
            5'h0b: param_byte = 8'h10;
            5'h0c: param_byte = `FSP_PARAM_TBL_PTR; // [R13]
            5'h0d: param_byte = 8'h00;
            5'h0e: param_byte = 8'h00;
            5'h0f: param_byte = `FSP_PARAM_ID_MSB; // [R13]
            default: param_byte = 8'hff;
        endcase
    end

    always @*
    begin
        is_write = (cmd_op == `FSP_OP_WR_SR) || (cmd_op == `FSP_OP_PROG) ||
                   (cmd_op == `FSP_OP_ERASE) || (cmd_op == `FSP_OP_CHIP_ERASE) ||
                   (cmd_op == `FSP_OP_WR_NVCR);
        state_d = state_q;
        cnt_d = cnt_q;
        lock_d = lock_q;
        anchor_d = anchor_q;
        extent_d = extent_q;
        wel_d = wel_q;
        reject_d = 1'b0;
        start_d = 1'b0;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (cmd_valid && is_write && !wel_q)
                begin
                    reject_d = 1'b1; // [R18]
                end
                else if (cmd_valid)
                begin
                    case (cmd_op)
                        `FSP_OP_RD_SR:
                        begin
                            rdata_d = status_now; // [R01]
                            rvalid_d = 1'b1;
                        end
                        `FSP_OP_RD_PARAM:
                        begin
                            rdata_d = param_byte; // [R13]
                            rvalid_d = 1'b1;
                        end
                        `FSP_OP_WREN:
                        begin
                            wel_d = 1'b1; // [R08]
                        end
                        `FSP_OP_WR_SR:
                        begin
                            if (hw_locked)
                            begin
                                reject_d = 1'b1; // [R02]
                            end
                            else
                            begin
                                lock_d = cmd_wdata[`FSP_SR_LOCK_BIT]; // [R01] [R04]
                                anchor_d = cmd_wdata[`FSP_SR_ANCHOR_BIT]; // [R05]
                                extent_d = {cmd_wdata[`FSP_SR_EXT3_BIT],
                                    cmd_wdata[`FSP_SR_EXT_LO_MSB:`FSP_SR_EXT_LO_LSB]}; // [R06]
                                cnt_d = `FSP_SR_WR_CYCLES;
                                state_d = ST_BUSY; // [R09]
                            end
                        end
                        `FSP_OP_WR_NVCR:
                        begin
                            cnt_d = `FSP_NVCR_WR_CYCLES;
                            state_d = ST_BUSY; // [R09]
                        end
                        `FSP_OP_PROG, `FSP_OP_ERASE:
                        begin
                            if (prot_hit)
                            begin
                                reject_d = 1'b1; // [R06]
                            end
                            else
                            begin
                                cnt_d = (cmd_op == `FSP_OP_PROG) ? `FSP_PROG_CYCLES
                                                                 : `FSP_ERASE_CYCLES;
                                start_d = 1'b1;
                                state_d = ST_BUSY; // [R09]
                            end
                        end
                        `FSP_OP_CHIP_ERASE:
                        begin
                            if (extent_q != 4'h0)
                            begin
                                reject_d = 1'b1; // [R15]
                            end
                            else
                            begin
                                cnt_d = `FSP_CHIP_CYCLES;
                                start_d = 1'b1;
                                state_d = ST_BUSY; // [R09]
                            end
                        end
                        default:
                        begin
                            reject_d = 1'b0;
                        end
                    endcase
                end
            end
            ST_BUSY:
            begin
                // Status stays readable while busy; writes bounce
                if (cmd_valid && cmd_op == `FSP_OP_RD_SR)
                begin
                    rdata_d = status_now; // [R01]
                    rvalid_d = 1'b1;
                end
                else if (cmd_valid && cmd_op != `FSP_OP_NOP)
                begin
                    reject_d = 1'b1; // [R18]
                end
                if (cnt_q == 16'h0001)
                begin
                    wel_d = 1'b0; // [R17]
                    state_d = ST_IDLE;
                end
                cnt_d = cnt_q - 16'h0001;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            // Nonvolatile bits return to their defaults with no backing cell
            {lock_q, anchor_q, extent_q} <= `FSP_NV_RESET; // [R04]
            wel_q <= 1'b0; // [R07]
            flash_status_q <= `FSP_SR_RESET;
            flag_ready_q <= 1'b1;
            rdata_q <= 8'h00;
            rdata_valid_q <= 1'b0;
            cmd_reject_q <= 1'b0;
            array_start_q <= 1'b0;
            bank_q <= 2'h0;
            sector_q <= 9'h000;
            sub32_q <= 10'h000;
            sub4_q <= 13'h0000;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            lock_q <= lock_d;
            anchor_q <= anchor_d;
            extent_q <= extent_d;
            wel_q <= wel_d;
            flash_status_q <= {lock_d, extent_d[3], anchor_d, extent_d[2:0], wel_d,
                               state_d == ST_BUSY}; // [R09]
            flag_ready_q <= (state_d != ST_BUSY); // [R16]
            rdata_q <= rdata_d;
            rdata_valid_q <= rvalid_d;
            cmd_reject_q <= reject_d;
            array_start_q <= start_d;
            if (cmd_valid)
            begin
                bank_q <= bank_w; // [R10] [R11]
                sector_q <= sector_w;
                sub32_q <= sub32_w;
                sub4_q <= sub4_w;
            end
        end
    end
endmodule // fsp_top
`default_nettype wire

// ---- tb/fsp_top_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fsp_regs.vh"
module fsp_top_checker #(
    parameter ADDR_W = 25
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        write_protect_n,
    input wire logic        sector_64k,
    input wire logic        cmd_valid,
    input wire logic [3:0]  cmd_op,
    input wire logic [24:0] cmd_addr,
    input wire logic [7:0]  cmd_wdata,
    input wire logic [7:0]  flash_status_q,
    input wire logic        flag_ready_q,
    input wire logic [7:0]  rdata_q,
    input wire logic        rdata_valid_q,
    input wire logic        cmd_reject_q,
    input wire logic        array_start_q,
    input wire logic [1:0]  bank_q,
    input wire logic [8:0]  sector_q,
    input wire logic [9:0]  sub32_q,
    input wire logic [12:0] sub4_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire       busy   = flash_status_q[0];
    wire       write_permit_latch    = flash_status_q[1];
    wire [3:0] ext    = {flash_status_q[6], flash_status_q[4:2]};
    wire       locked = flash_status_q[7] && !write_protect_n;
    wire       wr_ok  = cmd_valid && cmd_op == `FSP_OP_WR_SR && write_permit_latch && !busy;
    wire       wr_any = cmd_valid && cmd_op inside {`FSP_OP_WR_SR, `FSP_OP_PROG,
                        `FSP_OP_ERASE, `FSP_OP_CHIP_ERASE, `FSP_OP_WR_NVCR};

    ready_mirror_a: assert property (flag_ready_q == !busy)
        else $error("ready flag not inverse of busy");
    sr_lock_a: assert property (wr_ok && locked |=>
        cmd_reject_q && $stable(flash_status_q[7:2]))
        else $error("locked status write took effect");
    sr_write_a: assert property (wr_ok && !locked |=>
        (flash_status_q[7:2] == $past(cmd_wdata[7:2])) ##0 busy [*8] ##1 (!busy && !write_permit_latch))
        else $error("status write timing wrong");
    wel_set_a: assert property (cmd_valid && cmd_op == `FSP_OP_WREN && !busy |=> write_permit_latch)
        else $error("write enable did not set latch");
    no_permit_a: assert property (wr_any && !write_permit_latch |=>
        cmd_reject_q && !array_start_q && !busy)
        else $error("write without permit accepted");
    busy_reject_a: assert property (cmd_valid && busy && cmd_op != `FSP_OP_NOP
        && cmd_op != `FSP_OP_RD_SR |=> cmd_reject_q)
        else $error("command accepted while busy");
    chip_prot_a: assert property (cmd_valid && cmd_op == `FSP_OP_CHIP_ERASE && write_permit_latch
        && !busy && ext != 4'h0 |=> cmd_reject_q && !array_start_q)
        else $error("chip erase ran with protection set");
    rd_status_a: assert property (cmd_valid && cmd_op == `FSP_OP_RD_SR |=>
        rdata_valid_q && rdata_q == $past(flash_status_q))
        else $error("status read returned wrong value");
    map_64k_a: assert property (cmd_valid && sector_64k |=>
        sector_q == $past(cmd_addr[24:16]) && bank_q == $past(cmd_addr[24:23])
        && sub32_q == $past(cmd_addr[24:15]) && sub4_q == $past(cmd_addr[24:12]))
        else $error("64KB decode wrong");
    map_128k_a: assert property (cmd_valid && !sector_64k |=>
        sector_q == {1'b0, $past(cmd_addr[24:17])} && bank_q == $past(cmd_addr[24:23]))
        else $error("128KB decode wrong");

    cover property (wr_ok && locked);
    cover property (array_start_q);
    cover property (cmd_valid && cmd_op == `FSP_OP_RD_PARAM);
endmodule // fsp_top_checker
bind fsp_top fsp_top_checker #(.ADDR_W(ADDR_W)) fsp_top_checker_inst (.clk, .rst,
    .write_protect_n, .sector_64k, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata,
    .flash_status_q, .flag_ready_q, .rdata_q, .rdata_valid_q, .cmd_reject_q,
    .array_start_q, .bank_q, .sector_q, .sub32_q, .sub4_q);
`default_nettype wire

// ---- tb/fsp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module fsp_host (
    input  wire logic        clk,
    output logic             cmd_valid,
    output logic [3:0]       cmd_op,
    output logic [24:0]      cmd_addr,
    output logic [7:0]       cmd_wdata
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_op    = 4'h0;
        cmd_addr  = 25'h0;
        cmd_wdata = 8'h0;
    end
    task automatic issue(input logic [3:0] op, input logic [24:0] a, input logic [7:0] d);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_addr  = a;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        // Released lines must not keep looking valid
        cmd_op    = ~op;
        cmd_addr  = ~a;
        cmd_wdata = ~d;
    endtask
endmodule // fsp_host
`default_nettype wire

// ---- tb/flash_status_protect_map_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fsp_regs.vh"
module flash_status_protect_map_tb;
    logic        clk, rst, write_protect_n, sector_64k, cmd_valid;
    logic [3:0]  cmd_op;
    logic [24:0] cmd_addr;
    logic [7:0]  cmd_wdata, flash_status_q, rdata_q;
    logic        flag_ready_q, rdata_valid_q, cmd_reject_q, array_start_q;
    logic [1:0]  bank_q;
    logic [8:0]  sector_q;
    logic [9:0]  sub32_q;
    logic [12:0] sub4_q;
    int          err_total, n_checks;
    logic [7:0]  tsv [6] = '{8'h24, 8'h24, 8'h08, 8'h08, 8'h44, 8'h20};
    logic [24:0] tad [6] = '{25'h0000100, 25'h0020000, 25'h1fc0000, 25'h1fa0000,
                            25'h0fe0000, 25'h1fe0000};
    logic        trj [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [4:0]  pad [4] = '{5'd0, 5'd8, 5'd12, 5'd15};
    logic [7:0]  pex [4] = '{8'h53, `FSP_PARAM_ID_LSB, `FSP_PARAM_TBL_PTR, `FSP_PARAM_ID_MSB};

    fsp_top #(.ADDR_W(25)) fsp_top_inst (.clk, .rst, .write_protect_n, .sector_64k,
        .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .flash_status_q, .flag_ready_q,
        .rdata_q, .rdata_valid_q, .cmd_reject_q, .array_start_q, .bank_q, .sector_q,
        .sub32_q, .sub4_q);
    fsp_host fsp_host_inst (.clk, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata);

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp)
            begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
    endtask
    task automatic final_report();
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic go(input logic [3:0] op, input logic [24:0] a, input logic [7:0] d);
        fsp_host_inst.issue(op, a, d);
    endtask
    task automatic res(input logic rj, input logic st);
        chk({cmd_reject_q, array_start_q}, {rj, st});
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 400 && flash_status_q[0] !== 1'b0; i++)
            @(negedge clk);
        if (flash_status_q[0] !== 1'b0)
        begin
            err_total++;
            $display("[ERR] %0t busy never cleared", $time);
            final_report();
        end
    endtask
    task automatic wsr(input logic [7:0] v);
        go(`FSP_OP_WREN, 25'h0, 8'h00);
        go(`FSP_OP_WR_SR, 25'h0, v);
        wait_idle();
    endtask

    initial
    begin
        rst = 1'b1;
        write_protect_n = 1'b1;
        sector_64k = 1'b0;
        err_total = 0;
        n_checks = 0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk({flash_status_q, flag_ready_q}, {8'h00, 1'b1});
        go(`FSP_OP_WR_SR, 25'h0, 8'h24);
        res(1'b1, 1'b0);
        go(`FSP_OP_WREN, 25'h0, 8'h00);
        chk(flash_status_q, 8'h02);
        go(`FSP_OP_WR_SR, 25'h0, 8'h24);
        chk({flash_status_q, flag_ready_q}, {8'h27, 1'b0});
        go(`FSP_OP_WREN, 25'h0, 8'h00);
        res(1'b1, 1'b0);
        wait_idle();
        chk(flash_status_q, 8'h24);
        for (int i = 0; i < 6; i++)
        begin
            wsr(tsv[i]);
            chk(flash_status_q, tsv[i]);
            go(`FSP_OP_WREN, 25'h0, 8'h00);
            go(i[0] ? `FSP_OP_ERASE : `FSP_OP_PROG, tad[i], 8'h00);
            res(trj[i], !trj[i]);
            wait_idle();
        end
        wsr(8'h08);
        go(`FSP_OP_WREN, 25'h0, 8'h00);
        go(`FSP_OP_CHIP_ERASE, 25'h0, 8'h00);
        res(1'b1, 1'b0);
        wsr(8'h00);
        go(`FSP_OP_WREN, 25'h0, 8'h00);
        go(`FSP_OP_CHIP_ERASE, 25'h0, 8'h00);
        res(1'b0, 1'b1);
        wait_idle();
        wsr(8'h80);
        write_protect_n = 1'b0;
        go(`FSP_OP_WREN, 25'h0, 8'h00);
        go(`FSP_OP_WR_SR, 25'h0, 8'h00);
        chk({cmd_reject_q, flash_status_q}, {1'b1, 8'h82});
        write_protect_n = 1'b1;
        go(`FSP_OP_WR_SR, 25'h0, 8'h00);
        wait_idle();
        chk(flash_status_q, 8'h00);
        go(`FSP_OP_WREN, 25'h0, 8'h00);
        go(`FSP_OP_WR_NVCR, 25'h0, 8'h00);
        chk(flash_status_q, 8'h03);
        wait_idle();
        sector_64k = 1'b1;
        go(`FSP_OP_RD_SR, 25'h1ff0123, 8'h00);
        chk({rdata_valid_q, rdata_q}, {1'b1, 8'h00});
        chk({bank_q, sector_q, sub32_q, sub4_q}, {2'h3, 9'h1ff, 10'h3fe, 13'h1ff0});
        go(`FSP_OP_RD_SR, 25'h0010000, 8'h00);
        chk({bank_q, sector_q, sub32_q, sub4_q}, {2'h0, 9'h001, 10'h002, 13'h0010});
        sector_64k = 1'b0;
        go(`FSP_OP_RD_SR, 25'h0c20000, 8'h00);
        chk({bank_q, sector_q}, {2'h1, 9'h061});
        for (int i = 0; i < 4; i++)
        begin
            go(`FSP_OP_RD_PARAM, {20'h0, pad[i]}, 8'h00);
            chk(rdata_q, pex[i]);
        end
        // Mid-run reset must drop the permit latch again
        go(`FSP_OP_WREN, 25'h0, 8'h00);
        chk(flash_status_q, 8'h02);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk({flash_status_q, flag_ready_q}, {8'h00, 1'b1});
        go(`FSP_OP_RD_SR, 25'h0, 8'h00);
        chk({rdata_valid_q, rdata_q}, {1'b1, 8'h00});
        final_report();
    end
endmodule // flash_status_protect_map_tb
`default_nettype wire
